/* verilog/bsmi_pkg.sv */
// Constants, types and helpers shared by the microstep indexer.
// Assumes a single 100 MHz APB clock domain.
package bsmi_pkg;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned OSC_HZ      = 130_000;
    localparam logic [15:0] OSC_DIV_RST = 16'(CLK_HZ / OSC_HZ);
    localparam int unsigned DEAD_NS     = 300;
    localparam int unsigned DEAD_CYC    = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned BLANK_NS    = 1000;
    localparam int unsigned BLANK_CYC   = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [1:0]  CHOP_LAST   = 2'h3;
    localparam int unsigned VREF_MV     = 500;

    // ==================================================================
    // Register map
    localparam logic [11:0] REG_CTRL     = 12'h000;
    localparam logic [11:0] REG_STATUS   = 12'h004;
    localparam logic [11:0] REG_SETPOINT = 12'h008;
    localparam logic [11:0] REG_STEPS    = 12'h00C;
    localparam int unsigned CTRL_DIV_LSB = 0;
    localparam int unsigned ST_INDEX_LSB = 0;
    localparam int unsigned ST_RES_LSB   = 6;
    localparam int unsigned ST_HOME_BIT  = 8;
    localparam int unsigned ST_FAULT_BIT = 9;
    localparam int unsigned ST_EN_BIT    = 10;
    localparam int unsigned ST_RSTN_BIT  = 11;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {BSMI_CHARGE, BSMI_SLOW, BSMI_FAST} bsmi_mode_t;

    typedef struct packed {
        logic resolution_select_hi;
        logic resolution_select_lo;
        logic decay_select_hi;
        logic decay_select_lo;
        logic torque_select_hi;
        logic torque_select_lo;
    } bsmi_sel_t;

    typedef struct packed {
        logic u1;
        logic u2;
        logic l1;
        logic l2;
    } bsmi_bridge_t;

    // Phase current in percent of peak, angle k of 16 per quarter
    function automatic logic [6:0] bsmi_pct(input logic [4:0] k);
        logic [6:0] p;
        p = 7'h00;
        case (k)
            5'h00, 5'h01: p = 7'd100;
            5'h02: p = 7'd98;
            5'h03: p = 7'd96;
            5'h04: p = 7'd92;
            5'h05: p = 7'd88;
            5'h06: p = 7'd83;
            5'h07: p = 7'd77;
            5'h08: p = 7'd71;
            5'h09: p = 7'd63;
            5'h0A: p = 7'd56;
            5'h0B: p = 7'd47;
            5'h0C: p = 7'd38;
            5'h0D: p = 7'd29;
            5'h0E: p = 7'd20;
            5'h0F: p = 7'd10;
            default: p = 7'h00;
        endcase
        return p;
    endfunction

    function automatic bsmi_bridge_t bsmi_gates(input bsmi_mode_t m, input logic neg);
        bsmi_bridge_t g;
        g = 4'h3;
        case (m)
            BSMI_CHARGE: g = neg ? 4'h6 : 4'h9;
            BSMI_FAST:   g = neg ? 4'h9 : 4'h6;
            default:     g = 4'h3;
        endcase
        return g;
    endfunction

endpackage

/* verilog/bsmi_indexer.sv */
// Microstep indexer with chopping control and an APB register slave.
// Assumes select pins already synchronous-safe levels, step and direction pass two sync stages; sense
// comparators assert sense_trip when a sense node reaches its threshold.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module bsmi_indexer #(
    parameter int unsigned STEP_COUNT_W = 32
) (
    // Clock and reset
    input  wire  logic                    pclk,
    input  wire  logic                    presetn,
    // APB slave
    input  wire  logic                    psel,
    input  wire  logic                    penable,
    input  wire  logic                    pwrite,
    input  wire  logic [11:0]             paddr,
    input  wire  logic [31:0]             pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    // Host control pins
    input  wire  logic                    step_pulse,
    input  wire  logic                    rotation_direction,
    input  wire  logic                    indexer_reset_n,
    input  wire  logic                    output_enable,
    input  wire  bsmi_pkg::bsmi_sel_t     mode_pins,
    // Sensing and protection
    input  wire  logic [1:0]              sense_trip,
    input  wire  logic                    thermal_shutdown,
    // Bridge drive, index 0 is phase A
    output bsmi_pkg::bsmi_bridge_t [1:0]  bridge_gates,
    output logic [1:0][9:0]               sense_ref_mv,
    // Open-drain flags
    output logic                          home_flag_n_o,
    output logic                          home_flag_n_oe,
    output logic                          fault_n_o,
    output logic                          fault_n_oe
);
    import bsmi_pkg::*;

    if (STEP_COUNT_W < 8 || STEP_COUNT_W > 32) begin : g_bad_width
        $error("STEP_COUNT_W must lie in 8..32");
    end

    // ==================================================================
    // State
    typedef struct packed {
        logic [2:0]                    step_sync;
        logic [1:0]                    dir_sync;
        logic [5:0]                    index;
        logic [STEP_COUNT_W-1:0]       steps;
        logic [15:0]                   osc_div;
        logic [15:0]                   osc_cnt;
        logic [1:0]                    chop_cnt;
        logic                          step_pend;
        logic [7:0]                    blank_cnt;
        bsmi_mode_t [1:0]              mode;
        logic [1:0][5:0]               dead_cnt;
        bsmi_bridge_t [1:0]            gates;
        logic [1:0][9:0]               vref;
        logic                          home_oe;
        logic                          fault_oe;
        logic                          pready;
        logic [31:0]                   prdata;
        logic                          pslverr;
    } bsmi_st_t;

    localparam bsmi_st_t ST_RST = '{osc_div: OSC_DIV_RST, default: '0};

    bsmi_st_t st_r;
    bsmi_st_t st_nxt;

    // ==================================================================
    // Decoded settings and phase setpoints
    logic [1:0]       res;
    logic [5:0]       stride;
    logic [2:0]       fast_n;
    logic [6:0]       torque;
    logic             full;
    logic [1:0]       quad;
    logic [3:0]       ang;
    logic [1:0][6:0]  mag;
    logic [1:0]       neg;

    always_comb begin
        res = {mode_pins.resolution_select_hi, mode_pins.resolution_select_lo};
        full = (res == 2'h0);
        unique case (res)
            2'h0:    stride = 6'd16;
            2'h1:    stride = 6'd8;
            2'h2:    stride = 6'd1;
            default: stride = 6'd2;
        endcase
        unique case ({mode_pins.decay_select_hi, mode_pins.decay_select_lo})
            2'h0:    fast_n = 3'd0;
            2'h1:    fast_n = 3'd1;
            2'h2:    fast_n = 3'd2;
            default: fast_n = 3'd4;
        endcase
        unique case ({mode_pins.torque_select_hi, mode_pins.torque_select_lo})
            2'h0:    torque = 7'd100;
            2'h1:    torque = 7'd75;
            2'h2:    torque = 7'd50;
            default: torque = 7'd20;
        endcase
        // Full step sits one quarter back so position 0 gives A+, B-
        quad = full ? st_r.index[5:4] + 2'h3 : st_r.index[5:4];
        ang  = st_r.index[3:0];
        mag[0] = full ? 7'd100 : bsmi_pct(quad[0] ? 5'd16 - {1'b0, ang} : {1'b0, ang});
        mag[1] = full ? 7'd100 : bsmi_pct(quad[0] ? {1'b0, ang} : 5'd16 - {1'b0, ang});
        neg[0] = quad[0] ^ quad[1];
        neg[1] = quad[1];
    end

    // ==================================================================
    // Next-state logic
    logic             step_edge;
    logic             osc_tick;
    logic             period_start;
    logic             drive_ok;
    logic             apb_done;
    bsmi_mode_t       tgt_mode;
    bsmi_bridge_t     tgt_gates;
    logic [31:0]      rdata;
    logic             rerr;

    always_comb begin
        st_nxt = st_r;
        tgt_mode = BSMI_SLOW;
        tgt_gates = 4'h0;

        // Step input path; the first stage feeds only the second
        st_nxt.step_sync = {st_r.step_sync[1:0], step_pulse};
        st_nxt.dir_sync  = {st_r.dir_sync[0], rotation_direction};
        step_edge = st_r.step_sync[1] & ~st_r.step_sync[2];

        // Sequencer keeps running whatever the enable pin says
        if (!indexer_reset_n) begin
            st_nxt.index = 6'h00;
        end else if (step_edge) begin
            st_nxt.index = st_r.dir_sync[1] ? st_r.index - stride
                                            : st_r.index + stride;
            st_nxt.steps = st_r.steps + 1'b1;
        end

        // Chopping oscillator derived from pclk
        osc_tick = (st_r.osc_cnt >= st_r.osc_div - 16'h0001);
        st_nxt.osc_cnt = osc_tick ? 16'h0000 : st_r.osc_cnt + 16'h0001;

        // A step restarts the period at the next tick; a new edge wins
        period_start = 1'b0;
        if (osc_tick) begin
            period_start = st_r.step_pend || (st_r.chop_cnt == CHOP_LAST);
            st_nxt.chop_cnt = st_r.step_pend ? 2'h0 : st_r.chop_cnt + 2'h1;
            st_nxt.step_pend = step_edge && indexer_reset_n;
        end else if (step_edge && indexer_reset_n) begin
            st_nxt.step_pend = 1'b1;
        end

        if (st_r.blank_cnt != 8'h00) begin
            st_nxt.blank_cnt = st_r.blank_cnt - 8'h01;
        end
        if (period_start) begin
            // Brief charge so the current can be sensed
            st_nxt.blank_cnt = 8'(BLANK_CYC);
        end

        drive_ok = output_enable && !thermal_shutdown;

        for (int p = 0; p < 2; p++) begin
            st_nxt.vref[p] = 10'((VREF_MV * mag[p] * torque) / 10000);
            if (period_start) begin
                st_nxt.mode[p] = BSMI_CHARGE;
            end else if (st_r.mode[p] == BSMI_CHARGE && st_r.blank_cnt == 8'h00
                         && sense_trip[p]) begin
                st_nxt.mode[p] = BSMI_SLOW;
            end
            // Decay mixture: fast in the last fast_n cycles of four
            tgt_mode = st_nxt.mode[p];
            if (tgt_mode != BSMI_CHARGE && fast_n != 3'd0
                && {1'b0, st_nxt.chop_cnt} >= 3'd4 - fast_n) begin
                tgt_mode = BSMI_FAST;
            end
            tgt_gates = drive_ok ? bsmi_gates(tgt_mode, neg[p]) : 4'h0;

            // Changing switches rest off for the dead time
            if (st_r.dead_cnt[p] != 6'h00) begin
                st_nxt.dead_cnt[p] = st_r.dead_cnt[p] - 6'h01;
                st_nxt.gates[p] = st_r.gates[p] & tgt_gates;
                if (st_r.dead_cnt[p] == 6'h01) begin
                    st_nxt.gates[p] = tgt_gates;
                end
            end else if (tgt_gates != st_r.gates[p]) begin
                st_nxt.gates[p] = st_r.gates[p] & tgt_gates;
                st_nxt.dead_cnt[p] = 6'(DEAD_CYC);
            end
        end

        st_nxt.home_oe  = (st_nxt.index == 6'h00);
        st_nxt.fault_oe = thermal_shutdown;

        // APB: one wait state, answer registered
        rdata = 32'h0000_0000;
        rerr = 1'b0;
        unique case (paddr)
            REG_CTRL:     rdata[CTRL_DIV_LSB +: 16] = st_r.osc_div;
            REG_STATUS: begin
                rdata[ST_INDEX_LSB +: 6] = st_r.index;
                rdata[ST_RES_LSB +: 2]   = res;
                rdata[ST_HOME_BIT]       = st_r.home_oe;
                rdata[ST_FAULT_BIT]      = st_r.fault_oe;
                rdata[ST_EN_BIT]         = output_enable;
                rdata[ST_RSTN_BIT]       = indexer_reset_n;
            end
            REG_SETPOINT: rdata = {neg[1], 5'h00, st_r.vref[1], neg[0], 5'h00, st_r.vref[0]};
            REG_STEPS:    rdata[STEP_COUNT_W-1:0] = st_r.steps;
            default:      rerr = 1'b1;
        endcase
        apb_done = psel && penable && st_r.pready;
        st_nxt.pready = psel && penable && !st_r.pready;
        if (st_nxt.pready) begin
            st_nxt.prdata  = pwrite ? 32'h0000_0000 : rdata;
            st_nxt.pslverr = rerr;
        end
        if (apb_done && pwrite && !st_r.pslverr) begin
            if (paddr == REG_CTRL) begin
                st_nxt.osc_div = pwdata[CTRL_DIV_LSB +: 16];
            end else if (paddr == REG_STEPS) begin
                // Any write clears the step counter
                st_nxt.steps = '0;
            end
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================================================================
    // Outputs
    assign pready         = st_r.pready;
    assign prdata         = st_r.prdata;
    assign pslverr        = st_r.pslverr;
    assign bridge_gates   = st_r.gates;
    assign sense_ref_mv   = st_r.vref;
    assign home_flag_n_o  = 1'b0;
    assign home_flag_n_oe = st_r.home_oe;
    assign fault_n_o      = 1'b0;
    assign fault_n_oe     = st_r.fault_oe;

endmodule

/* verification/bsmi_indexer_props.sv */
// Port assertions for the microstep indexer.
// Bound to every bsmi_indexer; one pclk domain, presetn async low.
`timescale 1ns/1ns
module bsmi_indexer_props
    import bsmi_pkg::*;
(
    // Clock and APB
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic [11:0]            paddr,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Pins
    input wire logic                   step_pulse,
    input wire logic                   indexer_reset_n,
    input wire logic                   output_enable,
    input wire bsmi_pkg::bsmi_sel_t    mode_pins,
    input wire logic                   thermal_shutdown,
    input wire bsmi_pkg::bsmi_bridge_t [1:0] bridge_gates,
    input wire logic [1:0][9:0]        sense_ref_mv,
    input wire logic                   home_flag_n_o,
    input wire logic                   home_flag_n_oe,
    input wire logic                   fault_n_o,
    input wire logic                   fault_n_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Assertions
    gates_off_a: assert property (!output_enable [*2] |-> bridge_gates == '0)
        else $error("bridge on while disabled");
    fault_set_a: assert property (thermal_shutdown |=> fault_n_oe)
        else $error("fault flag not driven");
    // Reset-free cycles only: flags still show reset values at the release edge
    home_init_a: assert property ((presetn && !indexer_reset_n) [*2] |-> home_flag_n_oe)
        else $error("home flag off in initial state");
    home_leave_a: assert property (($rose(step_pulse) && home_flag_n_oe && indexer_reset_n)
        ##1 indexer_reset_n [*3] |=> !home_flag_n_oe) else $error("step did not leave home");
    od_low_a: assert property (!home_flag_n_o && !fault_n_o)
        else $error("open-drain level high");
    apb_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer timing");
    unmapped_a: assert property (psel && penable && pready && paddr > 12'h00C |-> pslverr)
        else $error("no error on unmapped");
    ref_init_a: assert property ((!indexer_reset_n && mode_pins[1:0] == 2'h0) [*4]
        |-> sense_ref_mv[0] == 10'd500) else $error("initial ref wrong");
    no_shoot_a: assert property (!(bridge_gates[0].u1 && bridge_gates[0].l1)
        && !(bridge_gates[0].u2 && bridge_gates[0].l2) && !(bridge_gates[1].u1
        && bridge_gates[1].l1) && !(bridge_gates[1].u2 && bridge_gates[1].l2))
        else $error("leg shoot-through");
    cover property (home_flag_n_oe ##1 !home_flag_n_oe);
    cover property (thermal_shutdown ##1 fault_n_oe);
    cover property (pready && pslverr);
endmodule

bind bsmi_indexer bsmi_indexer_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .step_pulse(step_pulse),
    .indexer_reset_n(indexer_reset_n), .output_enable(output_enable),
    .mode_pins(mode_pins), .thermal_shutdown(thermal_shutdown),
    .bridge_gates(bridge_gates), .sense_ref_mv(sense_ref_mv),
    .home_flag_n_o(home_flag_n_o), .home_flag_n_oe(home_flag_n_oe),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe)
);

/* verification/bsmi_step_host.sv */
// Host step controller model: one step pulse per request.
// Requests come on pclk edges; busy stays high until four cycles after the pulse ends.
`timescale 1ns/1ns
module bsmi_step_host (
    // Clock and request
    input  wire logic pclk,
    input  wire logic go,
    input  wire logic dir,
    // Pins to the indexer, and busy back to the requester
    output logic      step_pulse,
    output logic      rotation_direction,
    output logic      busy
);
    logic [3:0] cnt_r;
    initial begin
        step_pulse = 1'b0;
        rotation_direction = 1'b0;
        busy = 1'b0;
        cnt_r = 4'h0;
    end
    // Direction set well ahead of the rising step edge
    always @(posedge pclk) begin
        if (go && !busy) begin
            rotation_direction <= dir;
            busy <= 1'b1;
            cnt_r <= 4'h0;
        end else if (busy) begin
            cnt_r <= cnt_r + 4'h1;
            step_pulse <= cnt_r >= 4'h1 && cnt_r <= 4'h4;
            busy <= cnt_r != 4'h9;
        end
    end
endmodule

/* verification/bsmi_indexer_tb_top.sv */
// Self-checking bench for the microstep indexer.
// Needs bsmi_pkg, bsmi_indexer, the step host model and the checker.
`timescale 1ns/1ns
module bsmi_indexer_tb_top;
    import bsmi_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0;
    logic              go = 1'b0;
    logic              dir = 1'b0;
    logic              irst_n = 1'b0;
    logic              oe = 1'b1;
    logic              ts = 1'b0;
    logic [1:0]        trip = 2'h0;
    bsmi_sel_t         sel = '0;
    logic              pready, pslverr, stp, rdir, busy, err, f_oe, h_oe;
    logic [31:0]       prdata, rd;
    bsmi_bridge_t [1:0] gates;
    int                bad_count = 0;
    int                num_checks = 0;
    int                i;
    int                nf, ns;
    int                fexp [3] = '{0, 100, 260};
    logic [4:0]        strd [4] = '{5'd16, 5'd8, 5'd1, 5'd2};
    logic [9:0]        exa [4] = '{10'd500, 10'd355, 10'd500, 10'd490};
    logic [9:0]        exb [4] = '{10'd500, 10'd355, 10'd50, 10'd100};
    logic [9:0]        ext [4] = '{10'd500, 10'd375, 10'd250, 10'd100};
    always #5 pclk = ~pclk;
    bsmi_indexer DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .step_pulse(stp), .rotation_direction(rdir), .indexer_reset_n(irst_n),
        .output_enable(oe), .mode_pins(sel), .sense_trip(trip), .thermal_shutdown(ts),
        .bridge_gates(gates), .sense_ref_mv(), .home_flag_n_o(), .home_flag_n_oe(h_oe),
        .fault_n_o(), .fault_n_oe(f_oe)
    );
    bsmi_step_host u_host (
        .pclk(pclk), .go(go), .dir(dir), .step_pulse(stp), .rotation_direction(rdir),
        .busy(busy)
    );
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic step(input logic d);
        int n;
        n = 0;
        dir <= d;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy && n < 40);
        if (busy) bad_count++;
        repeat (4) @(posedge pclk);
    endtask
    // Settle two periods, then count phase A fast and slow cycles over two
    task automatic decay_run(input logic [1:0] d, output int nf_o, output int ns_o);
        nf_o = 0;
        ns_o = 0;
        sel[3:2] <= d;
        repeat (640) @(posedge pclk);
        repeat (640) begin
            @(posedge pclk);
            if (gates[0] == 4'h6) nf_o++;
            if (gates[0] == 4'h3) ns_o++;
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0301);
        apb(1'b1, 12'h000, 32'h0000_0014);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0014);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[7:0], err}, 9'h001);
        trip <= 2'h1;
        for (i = 0; i < 4; i++) begin
            sel[5:4] <= i[1:0];
            irst_n <= 1'b0;
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[8:0], {1'b1, i[1:0], 6'h00});
            apb(1'b0, 12'h008, 32'h0);
            chk({rd[31], rd[25:16], rd[9:0]}, {i == 0, i == 0 ? 10'd500 : 10'd0, 10'd500});
            irst_n <= 1'b1;
            step(1'b0);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[8:0], {1'b0, i[1:0], 1'b0, strd[i]});
            apb(1'b0, 12'h008, 32'h0);
            chk({rd[25:16], rd[9:0]}, {exb[i], exa[i]});
            step(1'b1);
            apb(1'b0, 12'h004, 32'h0);
            chk(rd[8:0], {1'b1, i[1:0], 6'h00});
        end
        step(1'b1);
        oe <= 1'b0;
        step(1'b0);
        step(1'b0);
        chk(gates, 8'h00);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[5:0], 6'h02);
        oe <= 1'b1;
        ts <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(f_oe, 1'b1);
        ts <= 1'b0;
        apb(1'b1, 12'h00C, 32'h0);
        chk(f_oe, 1'b0);
        step(1'b0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h1);
        irst_n <= 1'b0;
        step(1'b0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h1);
        for (i = 0; i < 4; i++) begin
            sel[1:0] <= i[1:0];
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0);
            chk(rd[9:0], ext[i]);
        end
        // Divider 80: period 320 cycles, long enough for blanking and dead time
        apb(1'b1, 12'h000, 32'h0000_0050);
        for (i = 0; i < 3; i++) begin
            decay_run(i[1:0], nf, ns);
            chk(nf, fexp[i]);
        end
        decay_run(2'h3, nf, ns);
        chk(ns, 32'h0);
        chk(nf > 260, 32'h1);
        chk(h_oe, 1'b1);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        tally_and_finish();
    end
endmodule
